// File: src/sector_protect_params.svh
// Purpose: constants of the sector protection and lock logic
// Assumes: 64 KB sectors inside a 24-bit byte address
// Notes:   sector count is a plain default, not a device figure
`ifndef SECTOR_PROTECT_PARAMS_SVH
`define SECTOR_PROTECT_PARAMS_SVH

// ==========================================================
// opcodes and sector geometry
`define SP_OPC_READ_PROT   8'h3c
`define SP_SECT_CNT        4
`define SP_SECT_W          2
`define SP_SECT_LSB        16
`define SP_ADDR_BITS       5'd24
`define SP_OPC_BITS        5'd8

// ==========================================================
// status write fields and values
`define SP_SR_LOCK_POS     7
`define SP_SR_GLOB_HI      5
`define SP_SR_GLOB_LO      2
`define SP_GLOB_UNPROT     4'h0
`define SP_GLOB_PROT       4'hf

// ==========================================================
// summary field codes and reset values
`define SP_SUMM_NONE       2'h0
`define SP_SUMM_SOME       2'h1
`define SP_SUMM_ALL        2'h3
`define SP_RST_FLAGS       4'h0
`define SP_RST_LOCK        1'b0
`define SP_RST_SYNC_HI     2'h3

`endif

// File: src/sector_protect_pkg.sv
// Purpose: types of the sector protection and lock logic
// Assumes: constants come from the params header
// Notes:   whole block state is one packed struct
`include "sector_protect_params.svh"

package sector_protect_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPC,
		ST_ADDR,
		ST_OUT,
		ST_SKIP
	} phase_t;

	typedef logic [`SP_SECT_CNT-1:0] flags_t;
	typedef logic [`SP_SECT_W-1:0]   sect_t;

	typedef struct packed {
		phase_t      phase;
		logic [4:0]  cnt;
		logic [23:0] sh;
		logic        rd_bit;
		logic        miso;
		logic        oe;
		flags_t      flags;
		logic        lock;
		logic        hw;
		logic [1:0]  summ;
		logic [2:0]  sclk_s;
		logic [1:0]  cs_s;
		logic [1:0]  mosi_s;
		logic [1:0]  wp_s;
	} state_t;

endpackage : sector_protect_pkg

// File: src/sector_protect_lock_logic.sv
// Purpose: protection read-back and lock logic of a serial flash
// Assumes: spi pins oversampled by mclk_i; spi clock well below mclk_i/4
// Notes:   sector commands and status writes arrive as same-clock pulses
//
// Summary of operation
// - read: opcode, three address bytes pick sector
// - result bit driven every clock after address
// - byte is 00h clear, ffh protected
// - chip select high ends read, releases output
// - read may stop anywhere without side effect
// - read result ignores write-protect pin
// - summary shows all, some or no sectors
// - pin never changes which sectors are protected
// - sector protected exactly when flag is 1
// - hardware lock: pin low and lock bit
// - hardware lock ignores protect, unprotect, status writes
// - unlock write never applies a global pattern
// - pin held low: only reset clears lock
// - software lock ignores sector and global changes
// - lock clears in software lock, sets when unlocked
// - setting lock may apply global pattern too
// - only lock bit stored from status write
// - unlocked: 0 clears all, all ones sets all
`include "sector_protect_params.svh"

module sector_protect_lock_logic (
	input  wire logic                       mclk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       spi_sclk_i,
	input  wire logic                       spi_cs_n_i,
	input  wire logic                       spi_mosi_i,
	input  wire logic                       wp_n_i,
	input  wire logic                       sect_protect_i,
	input  wire logic                       sect_unprotect_i,
	input  wire sector_protect_pkg::sect_t  sect_sel_i,
	input  wire logic                       status_wr_i,
	input  wire logic [7:0]                 status_wr_data_i,
	output logic                            spi_miso_o,
	output logic                            spi_miso_oe_o,
	output sector_protect_pkg::flags_t      sect_flags_o,
	output logic                            protect_flags_lock_bit_o,
	output logic                            hw_locked_o,
	output logic [1:0]                      soft_protect_summary_o
);
	import sector_protect_pkg::*;

	state_t q;
	state_t d;

	// ==========================================================
	// pin synchronisers and edge detection
	logic  cs_act;
	logic  sclk_rise;
	logic  sclk_fall;
	logic  mosi;
	logic  wp_low;
	logic  glob_hit_un;
	logic  glob_hit_pr;
	sect_t rd_sect;
	logic  [23:0] sh_nx;

	always_comb begin
		cs_act      = ~q.cs_s[1];
		sclk_rise   = q.sclk_s[1] & ~q.sclk_s[2];
		sclk_fall   = ~q.sclk_s[1] & q.sclk_s[2];
		mosi        = q.mosi_s[1];
		wp_low      = ~q.wp_s[1];
		sh_nx       = {q.sh[22:0], mosi};
		rd_sect     = sh_nx[`SP_SECT_LSB +: `SP_SECT_W];
		glob_hit_un = status_wr_data_i[`SP_SR_GLOB_HI:`SP_SR_GLOB_LO] == `SP_GLOB_UNPROT;
		glob_hit_pr = status_wr_data_i[`SP_SR_GLOB_HI:`SP_SR_GLOB_LO] == `SP_GLOB_PROT;
	end

	// ==========================================================
	// next state
	always_comb begin
		d        = q;
		d.sclk_s = {q.sclk_s[1:0], spi_sclk_i};
		d.cs_s   = {q.cs_s[0], spi_cs_n_i};
		d.mosi_s = {q.mosi_s[0], spi_mosi_i};
		d.wp_s   = {q.wp_s[0], wp_n_i};

		// serial side
		if (!cs_act) begin
			d.phase = ST_IDLE;
			d.oe    = 1'b0;
			d.miso  = 1'b0;
		end else begin
			case (q.phase)
				ST_IDLE: begin
					d.phase = ST_OPC;
					d.cnt   = '0;
				end
				ST_OPC: begin
					if (sclk_rise) begin
						d.sh  = sh_nx;
						d.cnt = q.cnt + 5'd1;
						if (q.cnt == `SP_OPC_BITS - 5'd1) begin
							d.cnt   = '0;
							d.phase = (sh_nx[7:0] == `SP_OPC_READ_PROT) ? ST_ADDR : ST_SKIP;
						end
					end
				end
				ST_ADDR: begin
					if (sclk_rise) begin
						d.sh  = sh_nx;
						d.cnt = q.cnt + 5'd1;
						if (q.cnt == `SP_ADDR_BITS - 5'd1) begin
							// only the stored flag, never the pin
							d.rd_bit = q.flags[rd_sect];
							d.phase  = ST_OUT;
						end
					end
				end
				ST_OUT: begin
					// same bit repeats the whole byte
					if (sclk_fall) begin
						d.miso = q.rd_bit;
						d.oe   = 1'b1;
					end
				end
				// leftover frames only wait for release
				ST_SKIP: d.phase = ST_SKIP;
				default: d.phase = ST_IDLE;
			endcase
		end

		// protection side
		// both conditions together
		if (wp_low && q.lock) begin
			d.lock = q.lock;
		end else if (status_wr_i) begin
			d.lock = status_wr_data_i[`SP_SR_LOCK_POS];
			if (!q.lock && glob_hit_un)
				d.flags = '0;
			else if (!q.lock && glob_hit_pr)
				d.flags = '1;
		end else if (!q.lock) begin
			if (sect_protect_i)
				d.flags[sect_sel_i] = 1'b1;
			else if (sect_unprotect_i)
				d.flags[sect_sel_i] = 1'b0;
		end

		// hw lock uses the next-state lock d.lock, i.e. the lock for next cycle
		d.hw = ~q.wp_s[1] & d.lock;

		if (&d.flags)
			d.summ = `SP_SUMM_ALL;
		else if (|d.flags)
			d.summ = `SP_SUMM_SOME;
		else
			d.summ = `SP_SUMM_NONE;
	end

	// ==========================================================
	// state register
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q       <= '0;
			q.cs_s  <= `SP_RST_SYNC_HI;
			q.wp_s  <= `SP_RST_SYNC_HI;
			q.flags <= `SP_RST_FLAGS;
			q.lock  <= `SP_RST_LOCK;
			q.phase <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	assign spi_miso_o               = q.miso;
	assign spi_miso_oe_o            = q.oe;
	assign sect_flags_o             = q.flags;
	assign protect_flags_lock_bit_o = q.lock;
	assign hw_locked_o              = q.hw;
	assign soft_protect_summary_o   = q.summ;

	// ==========================================================
	// assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	property p_cs_release;
		!cs_act |=> !spi_miso_oe_o ##1 !spi_miso_oe_o;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("output not released");

	property p_read_bit;
		(spi_miso_oe_o && q.phase == ST_OUT) |-> spi_miso_o == q.rd_bit;
	endproperty
	a_read_bit: assert property (p_read_bit) else $error("read byte not constant");

	property p_out_after_fall;
		(q.phase == ST_OUT && cs_act && sclk_fall) |=> spi_miso_oe_o;
	endproperty
	a_out_after_fall: assert property (p_out_after_fall) else $error("no output bit");

	property p_hw_frozen;
		(wp_low && q.lock) |=> ($stable(sect_flags_o) && protect_flags_lock_bit_o);
	endproperty
	a_hw_frozen: assert property (p_hw_frozen) else $error("hardware lock broken");

	property p_sw_clear;
		(!wp_low && q.lock && status_wr_i && !status_wr_data_i[`SP_SR_LOCK_POS])
			|=> (!protect_flags_lock_bit_o && $stable(sect_flags_o));
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("soft unlock wrong");

	property p_glob_unprot;
		(!q.lock && status_wr_i && glob_hit_un) |=> sect_flags_o == '0;
	endproperty
	a_glob_unprot: assert property (p_glob_unprot) else $error("global unprotect missed");

	property p_glob_prot;
		(!q.lock && status_wr_i && glob_hit_pr) |=> sect_flags_o == '1;
	endproperty
	a_glob_prot: assert property (p_glob_prot) else $error("global protect missed");

	property p_sw_sect;
		(q.lock && (sect_protect_i || sect_unprotect_i)) |=> $stable(sect_flags_o);
	endproperty
	a_sw_sect: assert property (p_sw_sect) else $error("locked sector changed");

	property p_summary;
		##1 (soft_protect_summary_o == `SP_SUMM_ALL) == (&sect_flags_o);
	endproperty
	a_summary: assert property (p_summary) else $error("summary wrong");

	property p_hw_out;
		hw_locked_o |-> protect_flags_lock_bit_o;
	endproperty
	a_hw_out: assert property (p_hw_out) else $error("hw lock without lock bit");

	property p_sect_set;
		(!q.lock && !status_wr_i && sect_protect_i) |=> sect_flags_o[$past(sect_sel_i)];
	endproperty
	a_sect_set: assert property (p_sect_set) else $error("sector protect missed");

	property p_sect_clr;
		(!q.lock && !status_wr_i && !sect_protect_i && sect_unprotect_i)
			|=> !sect_flags_o[$past(sect_sel_i)];
	endproperty
	a_sect_clr: assert property (p_sect_clr) else $error("sector unprotect missed");

	// the pin alone never moves a flag
	property p_flags_idle;
		!(status_wr_i || sect_protect_i || sect_unprotect_i) |=> $stable(sect_flags_o);
	endproperty
	a_flags_idle: assert property (p_flags_idle) else $error("flags moved");

	// spi traffic leaves the lock bit alone
	property p_lock_idle;
		!status_wr_i |=> $stable(protect_flags_lock_bit_o);
	endproperty
	a_lock_idle: assert property (p_lock_idle) else $error("lock moved");

	property p_sw_no_glob;
		(q.lock && !wp_low && status_wr_i) |=> $stable(sect_flags_o);
	endproperty
	a_sw_no_glob: assert property (p_sw_no_glob) else $error("global while locked");

	property p_lock_set;
		(!q.lock && status_wr_i && status_wr_data_i[`SP_SR_LOCK_POS])
			|=> protect_flags_lock_bit_o;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock not set");

	property p_lock_zero;
		(!q.lock && status_wr_i && !status_wr_data_i[`SP_SR_LOCK_POS])
			|=> !protect_flags_lock_bit_o;
	endproperty
	a_lock_zero: assert property (p_lock_zero) else $error("lock bit not stored");

	property p_out_quiet;
		!spi_miso_oe_o |-> !spi_miso_o;
	endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("released output not low");

	property p_skip_silent;
		(q.phase == ST_SKIP) |-> !spi_miso_oe_o;
	endproperty
	a_skip_silent: assert property (p_skip_silent) else $error("foreign opcode answered");

	// flag lags the synchronised pin by one cycle
	property p_hw_match;
		##1 hw_locked_o == ($past(wp_low) && protect_flags_lock_bit_o);
	endproperty
	a_hw_match: assert property (p_hw_match) else $error("hw lock flag wrong");

	property p_summary_none;
		##1 (soft_protect_summary_o == `SP_SUMM_NONE) == (sect_flags_o == '0);
	endproperty
	a_summary_none: assert property (p_summary_none) else $error("summary none wrong");

	c_read_out: cover property (q.phase == ST_OUT ##1 spi_miso_oe_o [*3] ##1 !cs_act);
	c_hw_lock: cover property (hw_locked_o && status_wr_i);
	c_glob: cover property (!q.lock && status_wr_i && glob_hit_pr ##1 q.lock);
	c_sw_unlock: cover property (q.lock && !wp_low && status_wr_i ##1 !q.lock);
	c_skip: cover property (q.phase == ST_SKIP ##1 !cs_act);

endmodule : sector_protect_lock_logic

// File: tb/spi_host_model.sv
// Purpose: host spi controller model for protection reads
// Assumes: mode 0, sclk half period of six mclk
// Notes:   sclk stands low between frames
module spi_host_model (
	input  wire logic mclk_i,
	input  wire logic spi_miso_i,
	input  wire logic spi_miso_oe_i,
	output logic      spi_sclk_o,
	output logic      spi_cs_n_o,
	output logic      spi_mosi_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 6;
	logic line;
	// released line shows the inverse, so a stale zero is never taken as data
	assign line = spi_miso_oe_i ? spi_miso_i : ~spi_miso_i;
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	task automatic read_prot(input logic [7:0] opc, input logic [23:0] addr, input int n,
		output logic [7:0] data, output logic [7:0] oe_bits);
		logic [31:0] frame;
		frame = {opc, addr};
		data = 8'h00;
		oe_bits = 8'h00;
		@(posedge mclk_i);
		spi_cs_n_o <= 1'b0;
		repeat (HALF) @(posedge mclk_i);
		for (int i = 31; i >= 0; i--) begin
			spi_mosi_o <= frame[i];
			repeat (HALF) @(posedge mclk_i);
			spi_sclk_o <= 1'b1;
			repeat (HALF) @(posedge mclk_i);
			spi_sclk_o <= 1'b0;
		end
		for (int j = 0; j < n; j++) begin
			repeat (HALF) @(posedge mclk_i);
			data = {data[6:0], line};
			oe_bits = {oe_bits[6:0], spi_miso_oe_i};
			spi_sclk_o <= 1'b1;
			repeat (HALF) @(posedge mclk_i);
			spi_sclk_o <= 1'b0;
		end
		repeat (HALF) @(posedge mclk_i);
		spi_cs_n_o <= 1'b1;
		repeat (HALF) @(posedge mclk_i);
	endtask : read_prot
endmodule : spi_host_model

// File: tb/sector_protect_lock_logic_bench.sv
// Purpose: self-checking bench of the sector protection and lock logic
// Assumes: host model drives the spi pins
// Notes:   state checked as {flags, lock, hw, summary}
module sector_protect_lock_logic_bench import sector_protect_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk_i, sys_rst_i, wp_n_i, sect_protect_i, sect_unprotect_i, status_wr_i;
	sect_t      sect_sel_i;
	logic [7:0] status_wr_data_i, rd, rd_oe;
	logic       sclk, cs_n, mosi, miso, oe, lock, hw;
	flags_t     flags;
	logic [1:0] summ;
	int         mismatches, n_tests;

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	sector_protect_lock_logic uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .wp_n_i(wp_n_i),
		.sect_protect_i(sect_protect_i), .sect_unprotect_i(sect_unprotect_i),
		.sect_sel_i(sect_sel_i), .status_wr_i(status_wr_i),
		.status_wr_data_i(status_wr_data_i), .spi_miso_o(miso), .spi_miso_oe_o(oe),
		.sect_flags_o(flags), .protect_flags_lock_bit_o(lock), .hw_locked_o(hw),
		.soft_protect_summary_o(summ));
	spi_host_model host (.mclk_i(mclk_i), .spi_miso_i(miso), .spi_miso_oe_i(oe),
		.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));

	// ==========================================================
	// tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic st(input logic [7:0] exp);
		chk({flags, lock, hw, summ}, exp);
	endtask : st
	// kind bits: status write, protect, unprotect
	task automatic pulse(input logic [2:0] k, input sect_t s, input logic [7:0] d);
		@(posedge mclk_i);
		{status_wr_i, sect_protect_i, sect_unprotect_i} <= k;
		sect_sel_i <= s;
		status_wr_data_i <= d;
		@(posedge mclk_i);
		{status_wr_i, sect_protect_i, sect_unprotect_i} <= 3'b000;
		@(negedge mclk_i);
	endtask : pulse
	task automatic set_wp(input logic v);
		@(posedge mclk_i);
		wp_n_i <= v;
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask : set_wp
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// tests
	initial begin
		repeat (20000) @(posedge mclk_i);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		{sys_rst_i, wp_n_i} = 2'b11;
		{status_wr_i, sect_protect_i, sect_unprotect_i} = 3'b000;
		sect_sel_i = 2'h0;
		status_wr_data_i = 8'h00;
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(negedge mclk_i);
		st(8'h00);
		pulse(3'b100, 2'h0, 8'h7f);
		st(8'hf3);
		pulse(3'b100, 2'h0, 8'h00);
		st(8'h00);
		pulse(3'b010, 2'h2, 8'h00);
		st(8'h41);
		host.read_prot(8'h3c, 24'h02abcd, 8, rd, rd_oe);
		chk(rd, 8'hff);
		chk(rd_oe, 8'hff);
		chk({6'h00, oe, miso}, 8'h00);
		host.read_prot(8'h3c, 24'h01ffff, 8, rd, rd_oe);
		chk(rd, 8'h00);
		host.read_prot(8'h9b, 24'h020000, 8, rd, rd_oe);
		chk(rd_oe, 8'h00);
		set_wp(1'b0);
		host.read_prot(8'h3c, 24'h020000, 8, rd, rd_oe);
		chk(rd, 8'hff);
		host.read_prot(8'h3c, 24'h02ffff, 3, rd, rd_oe);
		chk(rd, 8'h07);
		st(8'h41);
		pulse(3'b100, 2'h0, 8'hf0);
		st(8'h4d);
		pulse(3'b100, 2'h0, 8'h00);
		st(8'h4d);
		pulse(3'b001, 2'h2, 8'h00);
		st(8'h4d);
		set_wp(1'b1);
		st(8'h49);
		pulse(3'b010, 2'h0, 8'h00);
		st(8'h49);
		pulse(3'b100, 2'h0, 8'h7f);
		st(8'h41);
		pulse(3'b100, 2'h0, 8'hbc);
		st(8'hfb);
		set_wp(1'b0);
		st(8'hff);
		set_wp(1'b1);
		pulse(3'b100, 2'h0, 8'h00);
		st(8'hf3);
		pulse(3'b001, 2'h3, 8'h00);
		st(8'h71);
		// a hardware lock must drop on a mid-run reset
		set_wp(1'b0);
		pulse(3'b100, 2'h0, 8'hf0);
		st(8'h7d);
		@(posedge mclk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(negedge mclk_i);
		st(8'h00);
		pulse(3'b010, 2'h1, 8'h00);
		st(8'h21);
		tally_and_finish();
	end
endmodule : sector_protect_lock_logic_bench
